// ### include/jmd_cfg.svh
// Register map, field positions, reset values and ramp timing constants
`ifndef JMD_CFG_SVH
`define JMD_CFG_SVH

// Register indices; byte address is four times the index
`define JMD_IDX_PWR       10'h008
`define JMD_IDX_MICB      10'h04a
`define JMD_IDX_JACK      10'h04d
`define JMD_IDX_APOP      10'h04e
`define JMD_IDX_STAT      10'h050
`define JMD_IDX_SCLK      10'h051

// Field positions
`define JMD_PWR_MIC_BIT   8
`define JMD_PWR_VMID_BIT  2
`define JMD_PWR_DIV_HI    1
`define JMD_PWR_DIV_LO    0
`define JMD_MICB_MIC_BIT  7
`define JMD_MICB_INS_HI   4
`define JMD_MICB_INS_LO   2
`define JMD_MICB_SC_HI    1
`define JMD_MICB_SC_LO    0
`define JMD_JACK_L_BIT    15
`define JMD_JACK_R_BIT    14
`define JMD_APOP_HI       9
`define JMD_APOP_LO       8
`define JMD_SCLK_EN_BIT   0

// Reset values
`define JMD_RST_BIT       1'b0
`define JMD_RST_INS       3'h0
`define JMD_RST_SC        2'h0
`define JMD_RST_DIV       2'h0
`define JMD_RST_SPD       2'h0
`define JMD_RST_EVT       4'h0

// Mid-rail ramp: level range and step counter limits (pclk cycles per step minus one)
`define JMD_LVL_TOP       8'hff
`define JMD_LVL_BOT       8'h00
`define JMD_STEP_FAST     8'h01
`define JMD_STEP_MED      8'h03
`define JMD_STEP_SLOW     8'h07

`endif

// ### include/jmd_pkg.sv
// Types shared by the accessory-sense control modules
package jmd_pkg;

   typedef enum logic [1:0] {
      JMD_SPD_NONE = 2'b00,
      JMD_SPD_FAST = 2'b01,
      JMD_SPD_MED  = 2'b10,
      JMD_SPD_SLOW = 2'b11
   } jmd_speed_t;

   typedef enum logic [1:0] {
      JMD_DIV_OFF  = 2'b00,
      JMD_DIV_HIGH = 2'b01,
      JMD_DIV_MED  = 2'b10,
      JMD_DIV_LOW  = 2'b11
   } jmd_div_t;

   typedef enum logic [1:0] {
      JMD_RMP_IDLE = 2'b00,
      JMD_RMP_UP   = 2'b01,
      JMD_RMP_DOWN = 2'b10
   } jmd_ramp_st_t;

endpackage

// ### include/jmd_ramp_if.sv
// Link between the register block and the mid-rail ramp generator
`timescale 1ns/1ps
interface jmd_ramp_if;
   logic               ramp_on;
   jmd_pkg::jmd_speed_t speed;
   logic [7:0]         level;
   logic               busy;

   modport ctrl (output ramp_on, output speed, input level, input busy);
   modport ramp (input ramp_on, input speed, output level, output busy);
endinterface

// ### design/jmd_ramp.sv
// Mid-rail soft ramp generator with selectable S-curve speed
`timescale 1ns/1ps
`include "jmd_cfg.svh"
module jmd_ramp (
   input wire logic pclk,
   input wire logic presetn,
   jmd_ramp_if.ramp rif
);
   jmd_pkg::jmd_ramp_st_t st_q;
   jmd_pkg::jmd_ramp_st_t st_d;
   logic [7:0]            level_q;
   logic [7:0]            level_d;
   logic [7:0]            cnt_q;
   logic [7:0]            cnt_d;
   logic [7:0]            base;
   logic [7:0]            limit;
   logic                  at_end;
   logic                  edge_zone;
   logic                  step;
   logic [7:0]            target;

   assign target = rif.ramp_on ? `JMD_LVL_TOP : `JMD_LVL_BOT;
   assign base = (rif.speed == jmd_pkg::JMD_SPD_FAST) ? `JMD_STEP_FAST :
                 (rif.speed == jmd_pkg::JMD_SPD_MED)  ? `JMD_STEP_MED  :
                                                       `JMD_STEP_SLOW;
   // Slower steps near both ends give the S shape
   assign edge_zone = (level_q[7:6] == 2'b00) || (level_q[7:6] == 2'b11);
   assign limit = edge_zone ? {base[6:0], 1'b1} : base;
   assign at_end = (cnt_q >= limit);
   assign step = at_end && (level_q != target);

   always_comb begin
      st_d = st_q;
      level_d = level_q;
      cnt_d = at_end ? 8'h00 : cnt_q + 8'h01;
      unique case (st_q)
         jmd_pkg::JMD_RMP_IDLE: begin
            cnt_d = 8'h00;
            if (level_q != target) begin
               st_d = rif.ramp_on ? jmd_pkg::JMD_RMP_UP
                                  : jmd_pkg::JMD_RMP_DOWN;
            end
         end
         jmd_pkg::JMD_RMP_UP: begin
            if (!rif.ramp_on) begin
               st_d = jmd_pkg::JMD_RMP_DOWN;
            end else if (step) begin
               level_d = level_q + 8'h01;
            end else if (level_q == target) begin
               st_d = jmd_pkg::JMD_RMP_IDLE;
            end
         end
         jmd_pkg::JMD_RMP_DOWN: begin
            if (rif.ramp_on) begin
               st_d = jmd_pkg::JMD_RMP_UP;
            end else if (step) begin
               level_d = level_q - 8'h01;
            end else if (level_q == target) begin
               st_d = jmd_pkg::JMD_RMP_IDLE;
            end
         end
         default: st_d = jmd_pkg::JMD_RMP_IDLE;
      endcase
      // No ramp selected: the reference steps at once and will pop
      if (rif.speed == jmd_pkg::JMD_SPD_NONE) begin
         level_d = target;
         st_d = jmd_pkg::JMD_RMP_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= jmd_pkg::JMD_RMP_IDLE;
         level_q <= `JMD_LVL_BOT;
         cnt_q <= 8'h00;
      end else begin
         st_q <= st_d;
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end

   assign rif.level = level_q;
   assign rif.busy = (st_q != jmd_pkg::JMD_RMP_IDLE);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ramp_small_step;
      (rif.speed != jmd_pkg::JMD_SPD_NONE) &&
      ($past(rif.speed) != jmd_pkg::JMD_SPD_NONE) |->
         (level_q == $past(level_q)) ||
         (level_q == $past(level_q) + 8'h01) ||
         (level_q == $past(level_q) - 8'h01);
   endproperty
   a_ramp_small_step: assert property (p_ramp_small_step)
      else $error("mid-rail level jumped during a soft ramp");

   property p_no_ramp_step;
      rif.speed == jmd_pkg::JMD_SPD_NONE |=> level_q == $past(target);
   endproperty
   a_no_ramp_step: assert property (p_no_ramp_step)
      else $error("mid-rail level did not step with ramp off");

   sequence s_fast_rise;
      rif.ramp_on && rif.speed == jmd_pkg::JMD_SPD_FAST &&
      st_q == jmd_pkg::JMD_RMP_UP && !edge_zone && cnt_q == 8'h00;
   endsequence
   property p_fast_period;
      // The step lands two edges after the counter restarts
      s_fast_rise ##1 (rif.ramp_on && rif.speed == jmd_pkg::JMD_SPD_FAST)
         |=> level_q == $past(level_q, 2) + 8'h01 || level_q == target;
   endproperty
   a_fast_period: assert property (p_fast_period)
      else $error("fastest curve missed its step interval");
endmodule

// ### design/jmd_ctrl.sv
// Jack sense, microphone detect and mid-rail control with APB registers
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "jmd_cfg.svh"
// Behaviour
// - Left jack sense follows its enable bit
// - Right jack sense follows its enable bit
// - Enabled side reports jack state via event
// - Bias above insert threshold raises insert event
// - Bias above short threshold raises short event
// - Three-bit insert threshold, reset zero
// - Two-bit short threshold, reset zero
// - One mic enable bit, two register views
// - Mid-rail string follows its enable bit
// - Two-bit divider select, zero means off
// - Mid-rail starts and stops with soft ramp
// - Ramp speed: none, fast, medium, slow
module jmd_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slow_tick,
   input  wire logic        left_jack_level,
   input  wire logic        right_jack_level,
   input  wire logic        mic_above_insert,
   input  wire logic        mic_above_short,
   output logic             left_jack_sense_enable,
   output logic             right_jack_sense_enable,
   output logic             mic_sense_enable,
   output logic      [2:0]  insert_current_threshold,
   output logic      [1:0]  short_current_threshold,
   output logic             midrail_string_enable,
   output logic      [1:0]  midrail_divider,
   output logic      [7:0]  midrail_level,
   output logic             left_jack_event,
   output logic             right_jack_event,
   output logic             mic_insert_event,
   output logic             mic_short_event
);
   // Register state
   logic                jl_en_q;
   logic                jr_en_q;
   logic                mic_en_q;
   logic [2:0]          ins_thr_q;
   logic [1:0]          sc_thr_q;
   logic                vmid_en_q;
   jmd_pkg::jmd_div_t   div_q;
   jmd_pkg::jmd_speed_t spd_q;
   logic                sclk_en_q;
   logic [3:0]          evt_q;
   logic [3:0]          evt_d;
   logic                jl_st_q;
   logic                jr_st_q;
   logic                ins_seen_q;
   logic                sc_seen_q;
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;

   // Bus decode
   wire [9:0]  idx      = paddr[11:2];
   wire        sel_pwr  = (idx == `JMD_IDX_PWR);
   wire        sel_micb = (idx == `JMD_IDX_MICB);
   wire        sel_jack = (idx == `JMD_IDX_JACK);
   wire        sel_apop = (idx == `JMD_IDX_APOP);
   wire        sel_stat = (idx == `JMD_IDX_STAT);
   wire        sel_sclk = (idx == `JMD_IDX_SCLK);
   wire        hit      = sel_pwr | sel_micb | sel_jack |
                          sel_apop | sel_stat | sel_sclk;
   // One wait state: the answer is registered before pready rises
   wire        acc_first = psel & penable & ~pready_q;
   wire        apb_done  = psel & penable & pready_q;
   wire        wr_en     = apb_done & pwrite;
   wire        wr_pwr    = wr_en & sel_pwr;
   wire        wr_micb   = wr_en & sel_micb;
   wire        wr_jack   = wr_en & sel_jack;
   wire        wr_apop   = wr_en & sel_apop;
   wire        wr_stat   = wr_en & sel_stat;
   wire        wr_sclk   = wr_en & sel_sclk;

   // Link to the mid-rail ramp generator
   jmd_ramp_if rif ();

   // Read views
   wire [31:0] rd_pwr  = {16'h0000, 7'h00, mic_en_q, 5'h00,
                          vmid_en_q, div_q};
   wire [31:0] rd_micb = {16'h0000, 8'h00, mic_en_q, 2'b00,
                          ins_thr_q, sc_thr_q};
   wire [31:0] rd_jack = {16'h0000, jl_en_q, jr_en_q, 14'h0000};
   wire [31:0] rd_apop = {16'h0000, 6'h00, spd_q, 8'h00};
   wire [31:0] rd_stat = {24'h000000, 1'b0, rif.busy, jr_st_q,
                          jl_st_q, evt_q};
   wire [31:0] rd_sclk = {31'h00000000, sclk_en_q};
   wire [31:0] rd_word = sel_pwr  ? rd_pwr  :
                         sel_micb ? rd_micb :
                         sel_jack ? rd_jack :
                         sel_apop ? rd_apop :
                         sel_stat ? rd_stat :
                         sel_sclk ? rd_sclk : 32'h00000000;

   // Detection only acts on ticks of a running slow clock
   wire        det_tick = slow_tick & sclk_en_q;
   wire        jl_set   = det_tick & jl_en_q &
                          (left_jack_level != jl_st_q);
   wire        jr_set   = det_tick & jr_en_q &
                          (right_jack_level != jr_st_q);
   wire        ins_set  = det_tick & mic_en_q & mic_above_insert &
                          ~ins_seen_q;
   wire        sc_set   = det_tick & mic_en_q & mic_above_short &
                          ~sc_seen_q;
   wire [3:0]  evt_set  = {sc_set, ins_set, jr_set, jl_set};
   wire [3:0]  evt_clr  = wr_stat ? pwdata[3:0] : 4'h0;

   // Set beats a clear in the same cycle
   assign evt_d = evt_set | (evt_q & ~evt_clr);

   assign rif.ramp_on = vmid_en_q && (div_q != jmd_pkg::JMD_DIV_OFF);
   assign rif.speed   = spd_q;

   jmd_ramp jmd_ramp_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .rif     (rif)
   );

   // APB answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= acc_first;
         pslverr_q <= acc_first & ~hit;
         if (acc_first) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         jl_en_q   <= `JMD_RST_BIT;
         jr_en_q   <= `JMD_RST_BIT;
         mic_en_q  <= `JMD_RST_BIT;
         ins_thr_q <= `JMD_RST_INS;
         sc_thr_q  <= `JMD_RST_SC;
         vmid_en_q <= `JMD_RST_BIT;
         div_q     <= jmd_pkg::jmd_div_t'(`JMD_RST_DIV);
         spd_q     <= jmd_pkg::jmd_speed_t'(`JMD_RST_SPD);
         sclk_en_q <= `JMD_RST_BIT;
      end else begin
         if (wr_jack) begin
            jl_en_q <= pwdata[`JMD_JACK_L_BIT];
            jr_en_q <= pwdata[`JMD_JACK_R_BIT];
         end
         if (wr_pwr) begin
            mic_en_q  <= pwdata[`JMD_PWR_MIC_BIT];
            vmid_en_q <= pwdata[`JMD_PWR_VMID_BIT];
            div_q     <= jmd_pkg::jmd_div_t'(
                            pwdata[`JMD_PWR_DIV_HI:`JMD_PWR_DIV_LO]);
         end
         if (wr_micb) begin
            mic_en_q  <= pwdata[`JMD_MICB_MIC_BIT];
            ins_thr_q <= pwdata[`JMD_MICB_INS_HI:`JMD_MICB_INS_LO];
            sc_thr_q  <= pwdata[`JMD_MICB_SC_HI:`JMD_MICB_SC_LO];
         end
         if (wr_apop) begin
            spd_q <= jmd_pkg::jmd_speed_t'(
                        pwdata[`JMD_APOP_HI:`JMD_APOP_LO]);
         end
         if (wr_sclk) begin
            sclk_en_q <= pwdata[`JMD_SCLK_EN_BIT];
         end
      end
   end

   // Detection state and sticky events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q      <= `JMD_RST_EVT;
         jl_st_q    <= 1'b0;
         jr_st_q    <= 1'b0;
         ins_seen_q <= 1'b0;
         sc_seen_q  <= 1'b0;
      end else begin
         evt_q <= evt_d;
         // A disabled side forgets its state so enabling re-reports it
         if (!jl_en_q) begin
            jl_st_q <= 1'b0;
         end else if (det_tick) begin
            jl_st_q <= left_jack_level;
         end
         if (!jr_en_q) begin
            jr_st_q <= 1'b0;
         end else if (det_tick) begin
            jr_st_q <= right_jack_level;
         end
         if (!mic_en_q) begin
            ins_seen_q <= 1'b0;
            sc_seen_q  <= 1'b0;
         end else if (det_tick) begin
            ins_seen_q <= mic_above_insert;
            sc_seen_q  <= mic_above_short;
         end
      end
   end

   // Outputs straight from flip-flops
   assign prdata                   = prdata_q;
   assign pready                   = pready_q;
   assign pslverr                  = pslverr_q;
   assign left_jack_sense_enable   = jl_en_q;
   assign right_jack_sense_enable  = jr_en_q;
   assign mic_sense_enable         = mic_en_q;
   assign insert_current_threshold = ins_thr_q;
   assign short_current_threshold  = sc_thr_q;
   assign midrail_string_enable    = vmid_en_q;
   assign midrail_divider          = div_q;
   assign midrail_level            = rif.level;
   assign left_jack_event          = evt_q[0];
   assign right_jack_event         = evt_q[1];
   assign mic_insert_event         = evt_q[2];
   assign mic_short_event          = evt_q[3];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_left_en;
      wr_jack |=> left_jack_sense_enable == $past(pwdata[15]);
   endproperty
   a_left_en: assert property (p_left_en)
      else $error("left jack enable did not follow its write");

   property p_right_en;
      wr_jack |=> right_jack_sense_enable == $past(pwdata[14]);
   endproperty
   a_right_en: assert property (p_right_en)
      else $error("right jack enable did not follow its write");

   sequence s_left_change;
      det_tick && left_jack_sense_enable && left_jack_level != jl_st_q;
   endsequence
   property p_left_evt;
      s_left_change |=> left_jack_event && jl_st_q == $past(left_jack_level);
   endproperty
   a_left_evt: assert property (p_left_evt)
      else $error("left jack change not reported");

   property p_ins_evt;
      det_tick && mic_sense_enable && mic_above_insert && !ins_seen_q
         |=> mic_insert_event;
   endproperty
   a_ins_evt: assert property (p_ins_evt)
      else $error("mic insertion not reported");

   property p_short_evt;
      det_tick && mic_sense_enable && mic_above_short && !sc_seen_q
         |=> mic_short_event;
   endproperty
   a_short_evt: assert property (p_short_evt)
      else $error("mic short not reported");

   property p_thr_write;
      wr_micb |=> insert_current_threshold == $past(pwdata[4:2]) &&
                  short_current_threshold == $past(pwdata[1:0]) &&
                  rd_pwr[8] == $past(pwdata[7]);
   endproperty
   a_thr_write: assert property (p_thr_write)
      else $error("threshold fields did not follow their write");

   property p_mic_alias;
      wr_pwr |=> mic_sense_enable == $past(pwdata[8]) &&
                 rd_micb[7] == $past(pwdata[8]);
   endproperty
   a_mic_alias: assert property (p_mic_alias)
      else $error("mic enable views disagree");

   property p_vmid_write;
      wr_pwr |=> midrail_string_enable == $past(pwdata[2]) &&
                 midrail_divider == $past(pwdata[1:0]);
   endproperty
   a_vmid_write: assert property (p_vmid_write)
      else $error("mid-rail controls did not follow their write");

   property p_evt_sticky;
      evt_q[0] && !(wr_stat && pwdata[0]) |=> evt_q[0];
   endproperty
   a_evt_sticky: assert property (p_evt_sticky)
      else $error("left jack event dropped without a clear");

   property p_no_tick_no_evt;
      !det_tick |=> evt_q == ($past(evt_q) & ~$past(evt_clr));
   endproperty
   a_no_tick_no_evt: assert property (p_no_tick_no_evt)
      else $error("event raised outside a slow clock tick");

   property p_apb_answer;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("APB answer not given one cycle into access");
endmodule

// ### testbench/jmd_accessory_model.sv
// Behavioural jack socket and electret microphone with bias comparators
`timescale 1ns/1ps
module jmd_accessory_model (
   input  wire logic        pclk,
   input  wire logic        left_plugged,
   input  wire logic        right_plugged,
   input  wire logic [11:0] bias_ua,
   input  wire logic        mic_sense_enable,
   input  wire logic [2:0]  insert_current_threshold,
   input  wire logic [1:0]  short_current_threshold,
   output logic             left_jack_level = 1'b0,
   output logic             right_jack_level = 1'b0,
   output logic             mic_above_insert = 1'b0,
   output logic             mic_above_short = 1'b0
);
   function automatic logic [11:0] ins_ua(input logic [2:0] c);
      case (c)
         3'h0: ins_ua = 12'h0a0;
         3'h1: ins_ua = 12'h14a;
         3'h2: ins_ua = 12'h1f4;
         3'h3: ins_ua = 12'h2a8;
         3'h4: ins_ua = 12'h352;
         3'h5: ins_ua = 12'h3e8;
         3'h6: ins_ua = 12'h4b0;
         default: ins_ua = 12'h578;
      endcase
   endfunction

   function automatic logic [11:0] sc_ua(input logic [1:0] c);
      case (c)
         2'h0: sc_ua = 12'h190;
         2'h1: sc_ua = 12'h384;
         2'h2: sc_ua = 12'h546;
         default: sc_ua = 12'h708;
      endcase
   endfunction

   // Mic comparators are unpowered while mic sensing is off, so they read low; jack levels follow the plugs
   always @(posedge pclk) begin
      left_jack_level  <= left_plugged;
      right_jack_level <= right_plugged;
      mic_above_insert <= mic_sense_enable &&
                          (bias_ua > ins_ua(insert_current_threshold));
      mic_above_short  <= mic_sense_enable &&
                          (bias_ua > sc_ua(short_current_threshold));
   end
endmodule

// ### testbench/jmd_ctrl_tb_top.sv
// Self-checking bench for the accessory-sense control block
`timescale 1ns/1ps
`include "jmd_cfg.svh"
module jmd_ctrl_tb_top;
   typedef struct { logic [31:0] d; logic [31:0] m; logic e; } jmd_note_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, slow_tick = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000, bias_ua = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, wd;
   logic [2:0] tick_cnt = 3'h0, ins;
   logic l_plug = 1'b0, r_plug = 1'b0, l_lvl, r_lvl, m_ins, m_sc;
   logic l_en, r_en, m_en, ms_en, l_ev, r_ev, mi_ev, msc_ev;
   logic [2:0] ins_thr;
   logic [1:0] sc_thr, div;
   logic [7:0] lvl;
   int n_fail = 0, num_checks = 0, seed = 69, c, prev;
   jmd_note_t note_q[$];
   jmd_note_t nt;

   jmd_ctrl jmd_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_tick(slow_tick), .left_jack_level(l_lvl),
      .right_jack_level(r_lvl), .mic_above_insert(m_ins),
      .mic_above_short(m_sc), .left_jack_sense_enable(l_en),
      .right_jack_sense_enable(r_en), .mic_sense_enable(m_en),
      .insert_current_threshold(ins_thr), .short_current_threshold(sc_thr),
      .midrail_string_enable(ms_en), .midrail_divider(div),
      .midrail_level(lvl), .left_jack_event(l_ev), .right_jack_event(r_ev),
      .mic_insert_event(mi_ev), .mic_short_event(msc_ev));

   jmd_accessory_model jmd_accessory_model_inst (.pclk(pclk),
      .left_plugged(l_plug), .right_plugged(r_plug), .bias_ua(bias_ua),
      .mic_sense_enable(m_en), .insert_current_threshold(ins_thr),
      .short_current_threshold(sc_thr), .left_jack_level(l_lvl),
      .right_jack_level(r_lvl), .mic_above_insert(m_ins),
      .mic_above_short(m_sc));

   initial begin
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      tick_cnt  <= tick_cnt + 3'h1;
      slow_tick <= (tick_cnt == 3'h7);
   end

   task automatic print_verdict();
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t output %h expected %h", $time, got, exp);
      end
   endtask

   // Every transfer, write or read, leaves a note for the answer monitor
   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic [31:0] msk, input logic err);
      int n;
      note_q.push_back('{exp, msk, err});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 32'h0, 32'hffffffff, 1'b0);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, exp, 32'hffffffff, 1'b0);
   endtask

   task automatic wait_lvl(input logic [7:0] tgt, input int lim,
                           output int cnt);
      cnt = 0;
      while (lvl !== tgt && cnt < lim) begin
         @(posedge pclk);
         cnt++;
      end
   endtask

   always @(posedge pclk) begin
      if (presetn === 1'b1 && pready === 1'b1) begin
         num_checks++;
         if (note_q.size() == 0) begin
            n_fail++;
            $display("[FAIL] %0t unexpected bus answer", $time);
         end else begin
            nt = note_q.pop_front();
            if ((prdata & nt.m) !== (nt.d & nt.m) || pslverr !== nt.e) begin
               n_fail++;
               $display("[FAIL] %0t read %h expected %h", $time, prdata,
                        nt.d);
            end
         end
      end
   end

   initial begin
      #2400000;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(`JMD_IDX_SCLK, 32'h0);
      rd(`JMD_IDX_PWR, 32'h0);
      rd(`JMD_IDX_MICB, 32'h0);
      rd(`JMD_IDX_JACK, 32'h0);
      rd(`JMD_IDX_APOP, 32'h0);
      rd(`JMD_IDX_STAT, 32'h0);
      apb(1'b0, 10'h100, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, 10'h3ff, 32'hffff, 32'h0, 32'hffffffff, 1'b1);
      // Jack sensing, first with the slow clock stopped
      wd = $random(seed);
      wd[15:14] = 2'b10;
      wr(`JMD_IDX_JACK, wd);
      rd(`JMD_IDX_JACK, 32'h8000);
      chk({l_en, r_en}, 32'h2);
      l_plug <= 1'b1;
      r_plug <= 1'b1;
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h0);
      wr(`JMD_IDX_SCLK, 32'h1);
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h11);
      chk({l_ev, r_ev}, 32'h2);
      wr(`JMD_IDX_STAT, 32'h1);
      rd(`JMD_IDX_STAT, 32'h10);
      wr(`JMD_IDX_JACK, 32'hc000);
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h32);
      chk(r_ev, 32'h1);
      wr(`JMD_IDX_STAT, 32'h2);
      // Microphone: enable through the bias view, seen in both views
      ins = $random(seed);
      bias_ua <= 12'h064;
      wr(`JMD_IDX_MICB, {24'h0, 1'b1, 2'b00, ins, 2'b11});
      rd(`JMD_IDX_PWR, 32'h100);
      rd(`JMD_IDX_MICB, {24'h0, 1'b1, 2'b00, ins, 2'b11});
      chk({m_en, ins_thr, sc_thr}, {26'h0, 1'b1, ins, 2'b11});
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h30);
      bias_ua <= 12'h5dc;
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h34);
      chk({mi_ev, msc_ev}, 32'h2);
      bias_ua <= 12'h76c;
      repeat (24) @(posedge pclk);
      rd(`JMD_IDX_STAT, 32'h3c);
      chk(msc_ev, 32'h1);
      wr(`JMD_IDX_STAT, 32'hc);
      rd(`JMD_IDX_STAT, 32'h30);
      // Mid-rail with no ramp: target reached at once
      wr(`JMD_IDX_PWR, 32'h6);
      // Let the write edge pass before looking at the controls
      @(posedge pclk);
      chk({ms_en, div}, 32'h6);
      wait_lvl(8'hff, 3, c);
      chk(lvl, 32'hff);
      wr(`JMD_IDX_PWR, 32'h4);
      wait_lvl(8'h00, 3, c);
      chk(lvl, 32'h0);
      wr(`JMD_IDX_PWR, 32'h2);
      repeat (10) @(posedge pclk);
      chk(lvl, 32'h0);
      prev = 0;
      for (int s = 1; s < 4; s++) begin
         wr(`JMD_IDX_APOP, {22'h0, 2'(s), 8'h0});
         wr(`JMD_IDX_PWR, {29'h0, 1'b1, 2'(s)});
         apb(1'b0, `JMD_IDX_STAT, 32'h0, 32'h40, 32'h40, 1'b0);
         wait_lvl(8'hff, 8000, c);
         chk(lvl, 32'hff);
         chk(32'(c > prev && c > 250), 32'h1);
         prev = c;
         wr(`JMD_IDX_PWR, 32'h0);
         wait_lvl(8'h00, 8000, c);
         chk({lvl, 24'(c > 250)}, 32'h1);
      end
      print_verdict();
   end
endmodule
